/* hw/fci_pkg.sv */
// Purpose: shared constants and types for the filter control front end
// Assumes: core_clk at 200 MHz; link pins sampled by core_clk
// Notes:   latch layout and strap encodings live here only
package fci_pkg;

  // ---------------------------------------------------------------
  // control latch layout
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W         = 8;
  localparam int unsigned BIT_GAIN_LOW   = 7;
  localparam int unsigned BIT_GAIN_HIGH  = 6;
  localparam int unsigned BIT_CUT_LOW    = 5;
  localparam int unsigned BIT_CUT_HIGH   = 4;
  localparam int unsigned BIT_SHUTDOWN   = 1;
  localparam int unsigned BIT_GEN_OUT    = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int unsigned BIT_CNT_W      = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned SDO_DELAY_NS   = 125;
  localparam int unsigned SDO_DELAY_CYC  = SDO_DELAY_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FCI_CLK_EXTERNAL = 2'b00,
    FCI_CLK_INTERNAL = 2'b01,
    FCI_CLK_DRIVEN   = 2'b11
  } fci_clk_src_t;

  typedef struct packed {
    logic [1:0] gain_code;
    logic [1:0] cutoff_code;
    logic       shutdown;
  } fci_setting_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } fci_spi_t;

endpackage

/* hw/fci_spi_shift.sv */
// Purpose: spi slave shift register and control latch
// Assumes: inputs already synchronised to core_clk
// Notes:   edges found by comparing with previous sample
module fci_spi_shift
  import fci_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              enable,
  input  wire fci_spi_t          spi,
  output logic [CTRL_W-1:0]      latch_q,
  output logic                   sdo_q
);

  logic [CTRL_W-1:0] shift_q;
  logic              sclk_prev_q;
  logic              cs_prev_q;

  wire active    = enable & ~spi.cs_n;
  wire sclk_rise = active & spi.sclk & ~sclk_prev_q;
  wire sclk_fall = active & ~spi.sclk & sclk_prev_q;
  wire cs_rise   = enable & spi.cs_n & ~cs_prev_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_q     <= CTRL_RESET;
      latch_q     <= CTRL_RESET;
      sdo_q       <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= spi.sclk;
      // seen as high while disabled, so entering serial mode cannot load a stale latch
      cs_prev_q   <= spi.cs_n | ~enable;
      if (sclk_rise) begin
        shift_q <= {shift_q[CTRL_W-2:0], spi.sdi};
      end
      if (sclk_fall) begin
        sdo_q <= shift_q[CTRL_W-1];
      end
      if (cs_rise) begin
        latch_q <= shift_q;
      end
    end
  end

  property p_shift_in;
    @(posedge core_clk) disable iff (srst)
      sclk_rise |=> shift_q[0] == $past(spi.sdi);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("sdi not shifted in");

  property p_sdo_hold;
    @(posedge core_clk) disable iff (srst)
      !sclk_fall |=> $stable(sdo_q);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved off falling edge");

  property p_latch_load;
    @(posedge core_clk) disable iff (srst)
      cs_rise |=> latch_q == $past(shift_q);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_latch_hold;
    @(posedge core_clk) disable iff (srst)
      !cs_rise |=> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without cs rise");

endmodule

/* hw/fci_top.sv */
// Purpose: control front end, pin mode or serial mode, plus clock source select
// Assumes: all pins asynchronous to core_clk; sclk well below core_clk
// Notes:   three-level strap arrives pre-decoded as low/high flags
module fci_top
  import fci_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   srst,
  input  wire logic   interface_select_n,
  input  wire logic   cutoff_code_high,
  input  wire logic   cutoff_code_low,
  input  wire logic   sdi,
  input  wire logic   gain_code_high,
  input  wire logic   gain_code_low_in,
  input  wire logic   strap_low,
  input  wire logic   strap_high,
  input  wire logic   osc_clk,
  input  wire logic   master_clock_pin_in,
  output logic        sdo,
  output logic        gain_code_low_out,
  output logic        gain_code_low_oe,
  output logic        master_clock_pin_out,
  output logic        master_clock_pin_oe,
  output logic        strap_bias_en,
  output logic        filter_clk,
  output fci_clk_src_t clk_src,
  output fci_setting_t setting,
  output logic        general_output_bit
);

  // ---------------------------------------------------------------
  // two-stage synchronisers for every pin
  // ---------------------------------------------------------------
  localparam int unsigned NSYNC = 10;
  // select and chip select rest high, so reset is never followed by a serial-mode pulse
  localparam logic [NSYNC-1:0] SYNC_RST = 10'h300;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  assign pin_raw = {interface_select_n, cutoff_code_high, cutoff_code_low, sdi,
                    gain_code_high, gain_code_low_in, strap_low, strap_high,
                    osc_clk, master_clock_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (srst) begin
          meta_q[gi] <= SYNC_RST[gi];
          sync_q[gi] <= SYNC_RST[gi];
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire sel_n_s   = sync_q[9];
  wire cut_hi_s  = sync_q[8];
  wire cut_lo_s  = sync_q[7];
  wire sdi_s     = sync_q[6];
  wire gain_hi_s = sync_q[5];
  wire gain_lo_s = sync_q[4];
  wire st_low_s  = sync_q[3];
  wire st_high_s = sync_q[2];
  wire osc_s     = sync_q[1];
  wire mclk_s    = sync_q[0];

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  wire serial_mode = ~sel_n_s;

  fci_spi_t          spi_pins;
  logic [CTRL_W-1:0] latch;
  logic              sdo_shift;

  assign spi_pins.cs_n = cut_hi_s;
  assign spi_pins.sclk = cut_lo_s;
  assign spi_pins.sdi  = sdi_s;

  fci_spi_shift u_shift (
    .core_clk (core_clk),
    .srst     (srst),
    .enable   (serial_mode),
    .spi      (spi_pins),
    .latch_q  (latch),
    .sdo_q    (sdo_shift)
  );

  // ---------------------------------------------------------------
  // setting mux
  // ---------------------------------------------------------------
  fci_setting_t setting_d;
  fci_clk_src_t clk_src_d;

  // gain high pin is never read in serial mode
  assign setting_d.gain_code   = serial_mode ? {latch[BIT_GAIN_HIGH], latch[BIT_GAIN_LOW]}
                                             : {gain_hi_s, gain_lo_s};
  assign setting_d.cutoff_code = serial_mode ? {latch[BIT_CUT_HIGH], latch[BIT_CUT_LOW]}
                                             : {cut_hi_s, cut_lo_s};
  assign setting_d.shutdown    = serial_mode & latch[BIT_SHUTDOWN];

  // open strap reads neither low nor high thanks to the mid-supply bias
  assign clk_src_d = st_low_s  ? FCI_CLK_EXTERNAL :
                     st_high_s ? FCI_CLK_DRIVEN   : FCI_CLK_INTERNAL;

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      setting              <= '0;
      clk_src              <= FCI_CLK_INTERNAL;
      sdo                  <= 1'b0;
      gain_code_low_out    <= 1'b0;
      gain_code_low_oe     <= 1'b0;
      master_clock_pin_out <= 1'b0;
      master_clock_pin_oe  <= 1'b0;
      filter_clk           <= 1'b0;
      general_output_bit   <= 1'b0;
      strap_bias_en        <= 1'b1;
    end else begin
      setting            <= setting_d;
      clk_src            <= clk_src_d;
      strap_bias_en      <= 1'b1;
      sdo                <= sdo_shift;
      gain_code_low_out  <= latch[BIT_GEN_OUT];
      gain_code_low_oe   <= serial_mode;
      general_output_bit <= latch[BIT_GEN_OUT];
      filter_clk         <= (clk_src_d == FCI_CLK_EXTERNAL) ? mclk_s : osc_s;
      // weak pull-down modelled as a driven low while strap is open
      master_clock_pin_out <= (clk_src_d == FCI_CLK_DRIVEN) & osc_s;
      master_clock_pin_oe  <= (clk_src_d != FCI_CLK_EXTERNAL);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_pin_mode;
    sel_n_s ##1 sel_n_s;
  endsequence

  property p_pin_codes;
    @(posedge core_clk) disable iff (srst)
      s_pin_mode |=> setting.cutoff_code == $past(sync_q[8:7]);
  endproperty
  a_pin_codes: assert property (p_pin_codes) else $error("pin mode cutoff wrong");

  property p_serial_gain;
    @(posedge core_clk) disable iff (srst)
      !sel_n_s |=> setting.gain_code == $past({latch[BIT_GAIN_HIGH], latch[BIT_GAIN_LOW]});
  endproperty
  a_serial_gain: assert property (p_serial_gain) else $error("serial gain wrong");

  property p_no_shutdown_pin;
    @(posedge core_clk) disable iff (srst)
      sel_n_s |=> !setting.shutdown;
  endproperty
  a_no_shutdown_pin: assert property (p_no_shutdown_pin) else $error("shutdown in pin mode");

  property p_gain_oe;
    @(posedge core_clk) disable iff (srst)
      !sel_n_s |=> gain_code_low_oe && gain_code_low_out == $past(latch[BIT_GEN_OUT]);
  endproperty
  a_gain_oe: assert property (p_gain_oe) else $error("gain low pin not driving");

  property p_ext_clock;
    @(posedge core_clk) disable iff (srst)
      st_low_s |=> !master_clock_pin_oe && filter_clk == $past(mclk_s);
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external clock not used");

  property p_open_low;
    @(posedge core_clk) disable iff (srst)
      (!st_low_s && !st_high_s) |=> master_clock_pin_oe && !master_clock_pin_out;
  endproperty
  a_open_low: assert property (p_open_low) else $error("clock pin not held low");

  property p_drive_out;
    @(posedge core_clk) disable iff (srst)
      (!st_low_s && st_high_s) |=> master_clock_pin_out == $past(osc_s);
  endproperty
  a_drive_out: assert property (p_drive_out) else $error("clock not driven out");

  property p_sdo_follow;
    @(posedge core_clk) disable iff (srst)
      1'b1 |=> sdo == $past(sdo_shift);
  endproperty
  a_sdo_follow: assert property (p_sdo_follow) else $error("sdo not from shifter");

endmodule

/* verification/fci_spi_host.sv */
// Purpose: serial host model that drives the link pins of the filter control front end
// Assumes: core_clk paces every pin change; sdo is sampled just before each rising sclk
// Notes:   each sclk phase lasts 40 ns (80 ns period), faster than the pin timing asks;
//          the sampled port still sees every edge; sdi is inverted once a frame ends, so a stale bit
//          cannot pass for a held one
module fci_spi_host (
  input  wire logic core_clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF_CYC = 8;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // one whole byte; rx collects what the chain pushes out
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    wait_cyc(HALF_CYC);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      wait_cyc(HALF_CYC);
      rx[i] = sdo;
      sclk <= 1'b1;
      wait_cyc(HALF_CYC);
      sclk <= 1'b0;
    end
    wait_cyc(HALF_CYC);
    cs_n <= 1'b1;
    sdi  <= ~tx[0];
    wait_cyc(HALF_CYC);
  endtask

  // clocks with chip select high; these must not shift anything
  task automatic idle_clocks(input int n);
    sdi <= 1'b1;
    repeat (n) begin
      wait_cyc(HALF_CYC);
      sclk <= 1'b1;
      wait_cyc(HALF_CYC);
      sclk <= 1'b0;
    end
    wait_cyc(HALF_CYC);
  endtask
endmodule

/* verification/tb.sv */
// Purpose: self-checking bench for the filter control front end
// Assumes: 200 MHz core_clk; link pins come from the host model in serial mode
// Notes:   the bench resolves the two-way gain-low and clock pins from the enables
module tb
  import fci_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [1:0]   STRAP_TBL [3] = '{2'b10, 2'b00, 2'b01};
  localparam fci_clk_src_t SRC_TBL [3] = '{FCI_CLK_EXTERNAL, FCI_CLK_INTERNAL, FCI_CLK_DRIVEN};
  localparam logic [7:0]   BYTES [4] = '{8'hA6, 8'h5B, 8'hFF, 8'h00};

  logic         core_clk;
  logic         srst;
  logic         ser_n;
  logic [3:0]   pins;
  logic         strap_low;
  logic         strap_high;
  logic         osc_clk;
  logic         ext_clk;
  logic         h_cs_n;
  logic         h_sclk;
  logic         h_sdi;
  logic         sdo;
  logic         gl_out;
  logic         gl_oe;
  logic         mclk_out;
  logic         mclk_oe;
  logic         bias_en;
  logic         filter_clk;
  fci_clk_src_t clk_src;
  fci_setting_t setting;
  logic         gen_out;
  logic [7:0]   rx;
  int           error_cnt;
  int           comparisons;
  wire          gl_pin   = gl_oe ? gl_out : pins[2];
  wire          mclk_pin = mclk_oe ? mclk_out : ext_clk;
  wire          cut_hi   = ser_n ? pins[1] : h_cs_n;
  wire          cut_lo   = ser_n ? pins[0] : h_sclk;

  fci_top dut (.core_clk(core_clk), .srst(srst), .interface_select_n(ser_n),
    .cutoff_code_high(cut_hi), .cutoff_code_low(cut_lo), .sdi(h_sdi),
    .gain_code_high(pins[3]), .gain_code_low_in(gl_pin), .strap_low(strap_low),
    .strap_high(strap_high), .osc_clk(osc_clk), .master_clock_pin_in(mclk_pin),
    .sdo(sdo), .gain_code_low_out(gl_out), .gain_code_low_oe(gl_oe),
    .master_clock_pin_out(mclk_out), .master_clock_pin_oe(mclk_oe),
    .strap_bias_en(bias_en), .filter_clk(filter_clk), .clk_src(clk_src),
    .setting(setting), .general_output_bit(gen_out));

  fci_spi_host host (.core_clk(core_clk), .sdo(sdo), .cs_n(h_cs_n), .sclk(h_sclk),
    .sdi(h_sdi));

  always #2.5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic check_pins();
    ser_n <= 1'b1;
    for (int v = 0; v < 16; v++) begin
      pins <= v[3:0];
      cyc(6);
      chk({3'h0, setting}, {3'h0, v[3:0], 1'b0});
      chk({7'h0, gl_oe}, 8'h00);
    end
  endtask

  task automatic check_serial();
    ser_n <= 1'b0;
    cyc(8);
    chk({3'h0, setting}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pins[3] <= ~pins[3];
      host.xfer(BYTES[i], rx);
      cyc(8);
      chk({3'h0, setting}, {3'h0, BYTES[i][6], BYTES[i][7], BYTES[i][4], BYTES[i][5],
        BYTES[i][1]});
      chk({6'h0, gl_oe, gl_pin}, {6'h0, 1'b1, BYTES[i][0]});
      chk({7'h0, gen_out}, {7'h0, BYTES[i][0]});
      chk({7'h0, sdo}, {7'h0, BYTES[i][7]});
      if (i > 0) chk(rx, BYTES[i-1]);
    end
  endtask

  // stray clocks with chip select high leave the shifter untouched
  task automatic check_idle_clocks();
    host.idle_clocks(9);
    chk({7'h0, sdo}, 8'h00);
    host.xfer(8'h3C, rx);
    chk(rx, 8'h00);
  endtask

  task automatic check_strap();
    for (int m = 0; m < 3; m++) begin
      {strap_low, strap_high} <= STRAP_TBL[m];
      for (int lvl = 0; lvl < 2; lvl++) begin
        osc_clk <= (m == 0) ? ~lvl[0] : lvl[0];
        ext_clk <= (m == 0) ? lvl[0] : ~lvl[0];
        cyc(8);
        chk({6'h0, clk_src}, {6'h0, SRC_TBL[m]});
        chk({7'h0, mclk_oe}, {7'h0, m != 0});
        chk({7'h0, mclk_pin}, {7'h0, (m != 1) & lvl[0]});
        chk({7'h0, filter_clk}, {7'h0, lvl[0]});
        chk({7'h0, bias_en}, 8'h01);
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk    = 1'b0;
    srst        = 1'b1;
    ser_n       = 1'b1;
    pins        = 4'h0;
    strap_low   = 1'b0;
    strap_high  = 1'b0;
    osc_clk     = 1'b0;
    ext_clk     = 1'b0;
    error_cnt   = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    cyc(4);
    chk({4'h0, clk_src, sdo, bias_en}, 8'h05);
    chk({3'h0, setting}, 8'h00);
    chk({7'h0, gl_oe}, 8'h00);
    check_pins();
    check_serial();
    check_idle_clocks();
    check_strap();
    give_verdict();
  end

  // the whole sequence needs under 10 us; stop well after that
  initial begin
    #40us;
    error_cnt++;
    give_verdict();
  end
endmodule
